/* File: shared/tmric_pkg.sv */
// Constants, types and register map of the timer with interrupt control
package tmric_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_TMR_LO  = 8'hEA;
	localparam logic [7:0] IDX_TMR_HI  = 8'hEB;
	localparam logic [7:0] IDX_RLD_LO  = 8'hEC;
	localparam logic [7:0] IDX_RLD_HI  = 8'hED;
	localparam logic [7:0] IDX_CONTROL = 8'hEE;
	localparam logic [7:0] IDX_STATUS  = 8'hEF;
	localparam logic [7:0] IDX_PC_LO   = 8'hF0;
	localparam logic [7:0] IDX_PC_HI   = 8'hF1;
	localparam logic [7:0] IDX_COMMAND = 8'hF2;
	localparam logic [7:0] IDX_SP      = 8'hFD;

	// Control register fields
	localparam int CTL_MODE_LSB = 5;
	localparam int CTL_RUN      = 4;
	localparam int CTL_EXT_EDGE = 2;

	// Status register fields
	localparam int ST_GIE  = 0;
	localparam int ST_ENI  = 1;
	localparam int ST_EXT_IRQ_PENDING = 3;
	localparam int ST_TMR_IRQ_ENABLE = 4;
	localparam int ST_TMR_IRQ_PENDING = 5;

	// Values after reset
	localparam logic [7:0]  CONTROL_RST = 8'h00;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [14:0] PC_RST      = 15'h0000;
	localparam logic [7:0]  SP_RST      = 8'h00;
	localparam logic [15:0] CNT_RST     = 16'h0000;

	// Acknowledge sequence
	localparam logic [14:0] IRQ_VECTOR = 15'h00FF;
	localparam logic [2:0]  ACK_CYCLES = 3'h7;

	// Mode codes
	localparam logic [2:0] MODE_EVT_POS = 3'h0;
	localparam logic [2:0] MODE_EVT_NEG = 3'h1;
	localparam logic [2:0] MODE_RELOAD  = 3'h4;
	localparam logic [2:0] MODE_TOGGLE  = 3'h5;
	localparam logic [2:0] MODE_CAP_POS = 3'h6;
	localparam logic [2:0] MODE_CAP_NEG = 3'h7;

	// Command codes
	localparam logic [2:0] CMD_ACK     = 3'h1;
	localparam logic [2:0] CMD_SOFTINT = 3'h2;
	localparam logic [2:0] CMD_RET     = 3'h3;
	localparam logic [2:0] CMD_RETSKIP = 3'h4;
	localparam logic [2:0] CMD_RETIRQ  = 3'h5;

	typedef enum logic [0:0]
	{
		ST_IDLE = 1'b0,
		ST_SEQ  = 1'b1
	} tmric_state_t;

endpackage

/* File: hdl/tmric_top.sv */
// Timer/counter with interrupt control, AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tmric_top
(
	// Clock, reset, enable
	input  wire  logic        clk,
	input  wire  logic        rst,
	input  wire  logic        ce,
	// AHB-Lite slave
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic       [31:0] hrdata,
	output logic              hreadyout,
	output logic              hresp,
	// Timer pin
	input  wire  logic        timerPinIn,
	output logic              timerPinOut,
	output logic              timerPinOe,
	// External interrupt pin and request
	input  wire  logic        extIrqPin,
	output logic              irqReq
);

	// ==========================================================
	// State
	typedef struct packed
	{
		tmric_pkg::tmric_state_t state;
		logic [2:0]              seqCnt;
		logic                    wrPend;
		logic [7:0]              wrIdx;
		logic [15:0]             tmr;
		logic [15:0]             rld;
		logic [7:0]              ctl;
		logic [7:0]              stat;
		logic [14:0]             pc;
		logic [7:0]              sp;
		logic                    tPinPrev;
		logic                    ePinPrev;
		logic                    pinOut;
		logic                    pinOe;
		logic                    irq;
		logic [31:0]             rdata;
		logic                    rdy;
	} tmric_regs_t;

	tmric_regs_t r_q;
	tmric_regs_t r_d;

	logic [7:0] stackMem [0:255];
	logic       pushEn;
	logic [7:0] pushLoAddr;
	logic [7:0] pushHiAddr;
	logic [7:0] pushLoData;
	logic [7:0] pushHiData;

	// ==========================================================
	// Helpers
	function automatic logic selEdge(input logic cur, input logic prev, input logic falling);
		selEdge = falling ? (prev & ~cur) : (cur & ~prev);
	endfunction

	function automatic logic pendingReq(input logic [7:0] st);
		pendingReq = st[tmric_pkg::ST_GIE] &
			((st[tmric_pkg::ST_ENI] & st[tmric_pkg::ST_EXT_IRQ_PENDING]) |
			 (st[tmric_pkg::ST_TMR_IRQ_ENABLE] & st[tmric_pkg::ST_TMR_IRQ_PENDING]));
	endfunction

	function automatic logic inMap(input logic [31:0] addr);
		inMap = (addr[31:10] == 22'h000000);
	endfunction

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [2:0]  mode;
		logic        run;
		logic        tEdge;
		logic        step;
		logic        capture;
		logic        underflow;
		logic        tmrEvent;
		logic        extEvent;
		logic [2:0]  cmd;
		logic        cmdValid;
		logic [7:0]  popSp;
		logic [14:0] popPc;
		logic        tmrWr;
		mode       = 3'h0;
		run        = 1'b0;
		tEdge      = 1'b0;
		step       = 1'b0;
		capture    = 1'b0;
		underflow  = 1'b0;
		tmrEvent   = 1'b0;
		extEvent   = 1'b0;
		cmd        = 3'h0;
		cmdValid   = 1'b0;
		popSp      = 8'h00;
		popPc      = 15'h0000;
		tmrWr      = 1'b0;
		pushEn     = 1'b0;
		pushLoAddr = r_q.sp;
		pushHiAddr = r_q.sp - 8'h01;
		pushLoData = r_q.pc[7:0];
		pushHiData = {1'b0, r_q.pc[14:8]};
		r_d        = r_q;
		r_d.wrPend = 1'b0;
		r_d.rdy    = 1'b1;

		// ==========================================================
		// Data phase of a write
		if (r_q.wrPend)
		begin
			case (r_q.wrIdx)
				tmric_pkg::IDX_TMR_LO:
				begin
					r_d.tmr[7:0] = hwdata[7:0];
					tmrWr        = 1'b1;
				end
				tmric_pkg::IDX_TMR_HI:
				begin
					r_d.tmr[15:8] = hwdata[7:0];
					tmrWr         = 1'b1;
				end
				tmric_pkg::IDX_RLD_LO:  r_d.rld[7:0]  = hwdata[7:0];
				tmric_pkg::IDX_RLD_HI:  r_d.rld[15:8] = hwdata[7:0];
				tmric_pkg::IDX_CONTROL: r_d.ctl       = hwdata[7:0];
				tmric_pkg::IDX_STATUS:  r_d.stat      = hwdata[7:0];
				tmric_pkg::IDX_PC_LO:   r_d.pc[7:0]   = hwdata[7:0];
				tmric_pkg::IDX_PC_HI:   r_d.pc[14:8]  = hwdata[6:0];
				tmric_pkg::IDX_SP:      r_d.sp        = hwdata[7:0];
				tmric_pkg::IDX_COMMAND:
				begin
					cmd      = hwdata[2:0];
					cmdValid = 1'b1;
				end
				default: ;
			endcase
		end

		// ==========================================================
		// Pin edges
		// History starts low, so a pin high at release reads as a rising edge
		mode     = r_q.ctl[tmric_pkg::CTL_MODE_LSB +: 3];
		run      = r_q.ctl[tmric_pkg::CTL_RUN];
		tEdge    = selEdge(timerPinIn, r_q.tPinPrev, mode[0]);
		extEvent = selEdge(extIrqPin, r_q.ePinPrev,
			r_q.ctl[tmric_pkg::CTL_EXT_EDGE]);
		r_d.tPinPrev = timerPinIn;
		r_d.ePinPrev = extIrqPin;

		// ==========================================================
		// Counter: stopped counter holds
		case (mode)
			tmric_pkg::MODE_EVT_POS,
			tmric_pkg::MODE_EVT_NEG: step = run & tEdge;
			tmric_pkg::MODE_RELOAD,
			tmric_pkg::MODE_TOGGLE:  step = run;
			tmric_pkg::MODE_CAP_POS,
			tmric_pkg::MODE_CAP_NEG:
			begin
				step    = run;
				capture = run & tEdge;
			end
			default: step = 1'b0;
		endcase

		// Software load of a counter byte wins over the step, so a running timer can be reloaded
		if (step && !tmrWr)
		begin
			if (r_q.tmr == 16'h0000)
			begin
				underflow = 1'b1;
				r_d.tmr   = r_q.rld;
			end
			else
			begin
				r_d.tmr = r_q.tmr - 16'h0001;
			end
		end

		// Capture overrides a same-cycle software write of the register
		if (capture)
		begin
			r_d.rld = r_q.tmr;
		end

		tmrEvent = mode[1] ? capture : underflow;

		r_d.pinOe = (mode == tmric_pkg::MODE_TOGGLE);
		if (underflow && mode == tmric_pkg::MODE_TOGGLE)
		begin
			r_d.pinOut = ~r_q.pinOut;
		end

		// Hardware sets win over a same-cycle software clear
		if (extEvent)
		begin
			r_d.stat[tmric_pkg::ST_EXT_IRQ_PENDING] = 1'b1;
		end
		if (tmrEvent)
		begin
			r_d.stat[tmric_pkg::ST_TMR_IRQ_PENDING] = 1'b1;
		end

		// ==========================================================
		// Commands: acknowledge, software interrupt, returns
		popSp = r_q.sp + 8'h02;
		popPc = {stackMem[popSp - 8'h01][6:0], stackMem[popSp]};
		case (r_q.state)
			tmric_pkg::ST_IDLE:
			begin
				if (cmdValid)
				begin
					case (cmd)
						tmric_pkg::CMD_ACK:
						begin
							if (pendingReq(r_q.stat))
							begin
								pushEn                      = 1'b1;
								r_d.sp                      = r_q.sp - 8'h02;
								r_d.pc                      = tmric_pkg::IRQ_VECTOR;
								r_d.stat[tmric_pkg::ST_GIE] = 1'b0;
								r_d.state                   = tmric_pkg::ST_SEQ;
								r_d.seqCnt                  = tmric_pkg::ACK_CYCLES - 3'h1;
							end
						end
						tmric_pkg::CMD_SOFTINT:
						begin
							pushEn     = 1'b1;
							r_d.sp     = r_q.sp - 8'h02;
							r_d.pc     = tmric_pkg::IRQ_VECTOR;
							r_d.state  = tmric_pkg::ST_SEQ;
							r_d.seqCnt = tmric_pkg::ACK_CYCLES - 3'h1;
						end
						tmric_pkg::CMD_RET:
						begin
							r_d.sp = popSp;
							r_d.pc = popPc;
						end
						tmric_pkg::CMD_RETSKIP:
						begin
							r_d.sp = popSp;
							r_d.pc = popPc + 15'h0001;
						end
						tmric_pkg::CMD_RETIRQ:
						begin
							r_d.sp                      = popSp;
							r_d.pc                      = popPc;
							r_d.stat[tmric_pkg::ST_GIE] = 1'b1;
						end
						default: ;
					endcase
				end
			end
			tmric_pkg::ST_SEQ:
			begin
				// Commands during the sequence are dropped
				if (r_q.seqCnt == 3'h1)
				begin
					r_d.state = tmric_pkg::ST_IDLE;
				end
				r_d.seqCnt = r_q.seqCnt - 3'h1;
			end
			default: r_d.state = tmric_pkg::ST_IDLE;
		endcase

		// Request follows this cycle's flags, so a fresh event raises it at once
		r_d.irq = pendingReq(r_d.stat);

		// ==========================================================
		// Address phase
		if (hsel && htrans[1] && hready)
		begin
			r_d.wrPend = hwrite && inMap(haddr);
			r_d.wrIdx  = haddr[9:2];
			r_d.rdata  = 32'h00000000;
			if (!hwrite && inMap(haddr))
			begin
				case (haddr[9:2])
					tmric_pkg::IDX_TMR_LO:  r_d.rdata[7:0] = r_q.tmr[7:0];
					tmric_pkg::IDX_TMR_HI:  r_d.rdata[7:0] = r_q.tmr[15:8];
					tmric_pkg::IDX_RLD_LO:  r_d.rdata[7:0] = r_q.rld[7:0];
					tmric_pkg::IDX_RLD_HI:  r_d.rdata[7:0] = r_q.rld[15:8];
					tmric_pkg::IDX_CONTROL: r_d.rdata[7:0] = r_q.ctl;
					tmric_pkg::IDX_STATUS:  r_d.rdata[7:0] = r_q.stat;
					tmric_pkg::IDX_PC_LO:   r_d.rdata[7:0] = r_q.pc[7:0];
					tmric_pkg::IDX_PC_HI:   r_d.rdata[6:0] = r_q.pc[14:8];
					tmric_pkg::IDX_SP:      r_d.rdata[7:0] = r_q.sp;
					tmric_pkg::IDX_COMMAND:
					begin
						r_d.rdata[0] = (r_q.state == tmric_pkg::ST_SEQ);
						r_d.rdata[1] = r_q.irq;
					end
					default: r_d.rdata = 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			r_q          <= '0;
			r_q.state    <= tmric_pkg::ST_IDLE;
			r_q.tmr      <= tmric_pkg::CNT_RST;
			r_q.rld      <= tmric_pkg::CNT_RST;
			r_q.ctl      <= tmric_pkg::CONTROL_RST;
			r_q.stat     <= tmric_pkg::STATUS_RST;
			r_q.pc       <= tmric_pkg::PC_RST;
			r_q.sp       <= tmric_pkg::SP_RST;
			r_q.rdy      <= 1'b1;
		end
		else if (ce)
		begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Stack RAM: no reset, contents undefined until pushed
	always_ff @(posedge clk)
	begin
		if (ce && !rst && pushEn)
		begin
			stackMem[pushLoAddr] <= pushLoData;
			stackMem[pushHiAddr] <= pushHiData;
		end
	end

	// ==========================================================
	// Outputs
	// Slave never stalls or errors, so the bus sees zero wait states
	assign hrdata      = r_q.rdata;
	assign hreadyout   = r_q.rdy;
	assign hresp       = 1'b0;
	assign timerPinOut = r_q.pinOut;
	assign timerPinOe  = r_q.pinOe;
	assign irqReq      = r_q.irq;

endmodule

/* File: verif/tmric_assertions.sv */
// Port-level checks of the timer with interrupt control
`timescale 1ns/1ps
module tmric_assertions
(
	// Clock, reset, enable
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pins
	input wire logic        timerPinIn,
	input wire logic        timerPinOut,
	input wire logic        timerPinOe,
	input wire logic        extIrqPin,
	input wire logic        irqReq
);
	// ==========
	// Shadow of enables and mode, as software left them
	logic       take;
	logic       wSt_q, wCmd_q, wCtl_q;
	logic [2:0] en_q;
	logic [2:0] mode_q, mode2_q;
	assign take = hsel & htrans[1] & hready & ce;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wSt_q <= 1'b0;
			wCmd_q <= 1'b0;
			wCtl_q <= 1'b0;
			en_q <= 3'h0;
			mode_q <= 3'h0;
			mode2_q <= 3'h0;
		end
		else if (ce)
		begin
			wSt_q <= take & hwrite & (haddr == {22'h0, tmric_pkg::IDX_STATUS, 2'h0});
			wCmd_q <= take & hwrite & (haddr == {22'h0, tmric_pkg::IDX_COMMAND, 2'h0});
			wCtl_q <= take & hwrite & (haddr == {22'h0, tmric_pkg::IDX_CONTROL, 2'h0});
			mode2_q <= mode_q;
			if (wCtl_q)
				mode_q <= hwdata[tmric_pkg::CTL_MODE_LSB +: 3];
			if (wSt_q)
				en_q <= {hwdata[tmric_pkg::ST_TMR_IRQ_ENABLE], hwdata[tmric_pkg::ST_ENI], hwdata[tmric_pkg::ST_GIE]};
			else if (wCmd_q && hwdata[2:0] == tmric_pkg::CMD_ACK && irqReq)
				en_q[0] <= 1'b0;
			else if (wCmd_q && hwdata[2:0] == tmric_pkg::CMD_RETIRQ)
				en_q[0] <= 1'b1;
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_rd;
		take && !hwrite;
	endsequence
	sequence s_ack;
		ce && wCmd_q && hwdata[2:0] == tmric_pkg::CMD_ACK && irqReq;
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");
	AST_IRQ_GLOBAL: assert property (irqReq |-> en_q[0])
		else $error("request raised without global enable");
	AST_IRQ_SOURCE: assert property (irqReq |-> (en_q[1] | en_q[2]))
		else $error("request raised with both sources disabled");
	AST_ACK_DROPS_IRQ: assert property (s_ack |-> ##2 !irqReq)
		else $error("request still up after acknowledge");
	AST_PIN_DRIVEN_IN_TOGGLE: assert property (timerPinOe == (mode2_q == tmric_pkg::MODE_TOGGLE))
		else $error("timer pin enable does not follow the toggle mode");
	AST_PIN_TOGGLES_ONLY_IN_MODE: assert property (!$stable(timerPinOut) |-> $past(mode_q) == tmric_pkg::MODE_TOGGLE)
		else $error("timer pin level moved outside the toggle mode");
	AST_UNMAPPED_READS_ZERO: assert property (s_rd ##0 (haddr[31:10] != 22'h0) |=> hrdata == 32'h0)
		else $error("unmapped read returned data");
	AST_BYTE_WIDE_READS: assert property (s_rd |=> hrdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	AST_READ_DATA_STANDS: assert property (!take |=> $stable(hrdata))
		else $error("read data moved without a transfer");
endmodule

bind tmric_top tmric_assertions u_chk
(
	.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
	.extIrqPin(extIrqPin), .irqReq(irqReq)
);

/* File: verif/tmric_pin_src.sv */
// Behavioural source of timer pin and external interrupt pin events
`timescale 1ns/1ps
module tmric_pin_src
(
	// Clock
	input wire logic clk,
	// Event pins
	output logic     tPin,
	output logic     ePin
);
	initial
	begin
		tPin = 1'b0;
		ePin = 1'b0;
	end
	// Long holds model a slow source, short ones a prompt one
	task automatic drive(input logic ext, input logic v, input int hold);
		@(posedge clk);
		if (ext)
			ePin <= v;
		else
			tPin <= v;
		repeat (hold) @(posedge clk);
	endtask
endmodule

/* File: verif/tmric_test.sv */
// Self-checking bench for the timer with interrupt control
`timescale 1ns/1ps
module tmric_test;
	// ==========
	// Signals and bookkeeping
	logic        clk, rst, hsel, hwrite, rdPh, v, hreadyout, timerPinIn, timerPinOut, timerPinOe, irqReq, tPin, ePin;
	logic        ce;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rng;
	logic [31:0] expQ[$];
	string       nameQ[$];
	int          miscompares = 0;
	int          checks = 0;
	int          cyc = 0;
	logic [7:0]  holdCtl[3] = '{8'h00, 8'h50, 8'h70};
	// Control, counter high byte, index read, value, status
	logic [39:0] modeTab[4] = '{40'h1000EA1020, 40'h3000EA0000, 40'hD080ED7F20, 40'hF080ED7F20};
	// Wire level of the shared timer pin
	assign timerPinIn = timerPinOe ? timerPinOut : tPin;
	tmric_top uut
	(
		.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
		.extIrqPin(ePin), .irqReq(irqReq)
	);
	tmric_pin_src src (.clk(clk), .tPin(tPin), .ePin(ePin));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========
	// Tasks
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdPh <= !w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rdPh <= 1'b0;
	endtask
	task automatic rdA(input logic [31:0] a, input logic [7:0] e);
		expQ.push_back({24'h0, e});
		nameQ.push_back($sformatf("address %h", a));
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		rdA({22'h0, i, 2'h0}, e);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'b1, {22'h0, i, 2'h0}, {24'h0, d});
	endtask
	task automatic ld16(input logic [7:0] i, input logic [15:0] d);
		wr(i, d[7:0]);
		wr(i + 8'h01, d[15:8]);
	endtask
	task automatic cmd(input logic [2:0] c);
		wr(tmric_pkg::IDX_COMMAND, {5'h0, c});
		repeat (8) @(posedge clk);
	endtask
	// Read results are compared when their data phase completes
	always @(posedge clk)
		if (rdPh && hreadyout === 1'b1)
			chk(nameQ.pop_front(), hrdata, expQ.pop_front());
	// Ceiling at many times the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ==========
	// Scenarios
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		rdPh = 1'b0;
		rng = 32'h00013FE6;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(tmric_pkg::IDX_TMR_LO + 8'(i), 8'h00);
		rd(tmric_pkg::IDX_SP, 8'h00);
		xfer(1'b1, 32'h00000400, 32'h000000FF);
		rdA(32'h00000400, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			rng = xs(rng);
			wr(tmric_pkg::IDX_TMR_LO + 8'(i), rng[7:0]);
			rd(tmric_pkg::IDX_TMR_LO + 8'(i), rng[7:0]);
		end
		foreach (holdCtl[i])
		begin
			wr(tmric_pkg::IDX_CONTROL, holdCtl[i]);
			wr(tmric_pkg::IDX_TMR_LO, 8'h34);
			repeat (10) @(posedge clk);
			rd(tmric_pkg::IDX_TMR_LO, 8'h34);
		end
		$display("Test registers and hold done");
		ld16(tmric_pkg::IDX_TMR_LO, 16'h0000);
		ld16(tmric_pkg::IDX_RLD_LO, 16'h0003);
		wr(tmric_pkg::IDX_STATUS, 8'h11);
		wr(tmric_pkg::IDX_CONTROL, 8'h90);
		repeat (6) @(posedge clk);
		rd(tmric_pkg::IDX_STATUS, 8'h31);
		rd(tmric_pkg::IDX_COMMAND, 8'h02);
		wr(tmric_pkg::IDX_CONTROL, 8'h80);
		cmd(tmric_pkg::CMD_ACK);
		rd(tmric_pkg::IDX_STATUS, 8'h30);
		rd(tmric_pkg::IDX_PC_LO, 8'hFF);
		rd(tmric_pkg::IDX_SP, 8'hFE);
		wr(tmric_pkg::IDX_STATUS, 8'h31);
		repeat (3) @(posedge clk);
		cmd(tmric_pkg::CMD_ACK);
		rd(tmric_pkg::IDX_SP, 8'hFC);
		cmd(tmric_pkg::CMD_RETIRQ);
		rd(tmric_pkg::IDX_PC_LO, 8'hFF);
		rd(tmric_pkg::IDX_STATUS, 8'h31);
		cmd(tmric_pkg::CMD_RET);
		rd(tmric_pkg::IDX_SP, 8'h00);
		wr(tmric_pkg::IDX_STATUS, 8'h01);
		cmd(tmric_pkg::CMD_SOFTINT);
		rd(tmric_pkg::IDX_STATUS, 8'h01);
		wr(tmric_pkg::IDX_STATUS, 8'h00);
		cmd(tmric_pkg::CMD_RETSKIP);
		rd(tmric_pkg::IDX_PC_LO, 8'h01);
		rd(tmric_pkg::IDX_STATUS, 8'h00);
		$display("Test interrupt sequences done");
		for (int s = 0; s < 2; s++)
		begin
			wr(tmric_pkg::IDX_STATUS, 8'h02);
			wr(tmric_pkg::IDX_CONTROL, s ? 8'h04 : 8'h00);
			src.drive(1'b1, 1'b1, 3);
			rd(tmric_pkg::IDX_STATUS, s ? 8'h02 : 8'h0A);
			src.drive(1'b1, 1'b0, 3 + 5 * s);
			rd(tmric_pkg::IDX_STATUS, 8'h0A);
		end
		foreach (modeTab[i])
		begin
			wr(tmric_pkg::IDX_CONTROL, modeTab[i][39:32] & 8'hEF);
			ld16(tmric_pkg::IDX_TMR_LO, {modeTab[i][31:24], 8'h01});
			ld16(tmric_pkg::IDX_RLD_LO, 16'h0010);
			wr(tmric_pkg::IDX_STATUS, 8'h00);
			wr(tmric_pkg::IDX_CONTROL, modeTab[i][39:32]);
			src.drive(1'b0, 1'b1, 4);
			src.drive(1'b0, 1'b0, 4);
			src.drive(1'b0, 1'b1, 4);
			rd(modeTab[i][23:16], modeTab[i][15:8]);
			rd(tmric_pkg::IDX_STATUS, modeTab[i][7:0]);
			src.drive(1'b0, 1'b0, 2);
		end
		$display("Test pin events done");
		// Stop the capture count so the loads below stand
		wr(tmric_pkg::IDX_CONTROL, 8'h00);
		ld16(tmric_pkg::IDX_TMR_LO, 16'h0000);
		ld16(tmric_pkg::IDX_RLD_LO, 16'h0003);
		wr(tmric_pkg::IDX_CONTROL, 8'hB0);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			v = timerPinOut;
			repeat (4) @(posedge clk);
			chk("timer pin", {31'h0, timerPinOut}, {31'h0, ~v});
		end
		// Six frozen edges span an underflow that would otherwise toggle the pin
		v = timerPinOut;
		ce <= 1'b0;
		repeat (6) @(posedge clk);
		chk("frozen pin", {31'h0, timerPinOut}, {31'h0, v});
		ce <= 1'b1;
		$display("Test toggle output done");
		tally_and_finish();
	end
endmodule
